/* src/fvc_device.sv */
// Device end: memory size registers, pulse counting and serial link selection.
// Assumes a byte-wide CPU write/read port on i_clk and link pins from the programmer.
`timescale 1ns/100ps
module fvc_device (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_tx_byte,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [3:0] o_rom_size_field,
  output logic [2:0] o_hram_size_field,
  output logic o_rom_setting_valid,
  output logic o_xram_512,
  output logic o_prog_mode,
  output fvc_pkg::fvc_link_t o_link,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  fvc_link_if.device link
);
  import fvc_pkg::*;

  typedef enum {FVC_IDLE, FVC_COUNT, FVC_ACTIVE} fvc_state_t;

  // Two-flop synchronisers for every pin input except main_clock_input
  logic [6:0] pin_meta; // First stage, read only by the second
  logic [6:0] pin_sync; // Second stage
  logic [6:0] pin_prev; // For edge detection
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
      pin_prev <= 7'h00;
    end else if (i_ce) begin
      pin_meta <= {link.vpp, link.port_a_serial_in, link.port_a_serial_clock, link.port_b_serial_in,
                   link.port_b_serial_clock, link.async_receive, link.reset_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  logic vpp_s, a_in_s, a_clk_s, b_in_s, b_clk_s, rx_s, prst_s;
  assign {vpp_s, a_in_s, a_clk_s, b_in_s, b_clk_s, rx_s, prst_s} = pin_sync;
  logic vpp_rise, a_clk_rise, a_clk_fall, b_clk_rise, b_clk_fall;
  assign vpp_rise = vpp_s & ~pin_prev[6];
  assign a_clk_rise = a_clk_s & ~pin_prev[4];
  assign a_clk_fall = ~a_clk_s & pin_prev[4];
  assign b_clk_rise = b_clk_s & ~pin_prev[2];
  assign b_clk_fall = ~b_clk_s & pin_prev[2];

  // Register file
  logic [7:0] mem_size_select, next_mem_size_select;
  logic [7:0] expansion_ram_size_select, next_expansion_ram_size_select;
  logic [7:0] next_rdata;
  logic next_rvalid;
  // Register next-state: byte writes, reserved bits forced zero
  always_comb begin
    next_mem_size_select = mem_size_select;
    next_expansion_ram_size_select = expansion_ram_size_select;
    next_rdata = o_rdata;
    next_rvalid = 1'b0;
    if (i_wr && i_addr == MSS_ADDR) begin
      next_mem_size_select = i_wdata & 8'hef;
    end
    if (i_wr && i_addr == XRS_ADDR) begin
      next_expansion_ram_size_select = {4'h0, i_wdata[3:0]};
    end
    if (i_rd) begin
      next_rvalid = 1'b1;
      if (i_addr == MSS_ADDR) begin
        next_rdata = mem_size_select;
      end else if (i_addr == XRS_ADDR) begin
        next_rdata = expansion_ram_size_select;
      end else begin
        next_rdata = 8'h00; // Unmapped reads zero
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_size_select <= MSS_RESET;
      expansion_ram_size_select <= XRS_RESET;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      mem_size_select <= next_mem_size_select;
      expansion_ram_size_select <= next_expansion_ram_size_select;
      o_rdata <= next_rdata;
      o_rvalid <= next_rvalid;
    end
  end

  // Decoded size outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rom_size_field <= 4'h0;
      o_hram_size_field <= 3'h0;
      o_rom_setting_valid <= 1'b0;
      o_xram_512 <= 1'b0;
    end else if (i_ce) begin
      o_rom_size_field <= mem_size_select[ROM_LSB +: 4];
      o_hram_size_field <= mem_size_select[HRAM_LSB +: 3];
      // Prohibited codes flag invalid
      o_rom_setting_valid <= (mem_size_select[ROM_LSB +: 4] == ROM_CODE_24K) ||
                             (mem_size_select[ROM_LSB +: 4] == ROM_CODE_32K);
      o_xram_512 <= expansion_ram_size_select[3:0] == XRAM_CODE_512;
    end
  end

  // Entry state machine: count pulses after reset release with voltage present
  fvc_state_t state, next_state;
  logic [3:0] pulses, next_pulses;
  logic [12:0] quiet, next_quiet;
  fvc_link_t link_sel, next_link_sel;
  always_comb begin
    next_state = state;
    next_pulses = pulses;
    next_quiet = quiet;
    next_link_sel = link_sel;
    case (state)
      FVC_IDLE: begin
        // Programming only when voltage present at reset release
        if (vpp_s && prst_s) begin
          next_state = FVC_COUNT;
          next_pulses = 4'h0;
          next_quiet = 13'h0000;
        end
      end
      FVC_COUNT: begin
        // A pulse is a low phase of the voltage; restart quiet time on it
        if (vpp_rise) begin
          next_pulses = pulses + 4'h1;
          next_quiet = 13'h0000;
        end else if (!vpp_s) begin
          next_quiet = 13'h0000;
        end else if (quiet == 13'(PULSE_WINDOW_CYC - 1)) begin
          next_state = FVC_ACTIVE;
          case (pulses)
            PULSES_PORT_A: next_link_sel = FVC_LINK_A;
            PULSES_PORT_A_HS: next_link_sel = FVC_LINK_A_HS;
            PULSES_PORT_B: next_link_sel = FVC_LINK_B;
            PULSES_ASYNC: next_link_sel = FVC_LINK_ASYNC;
            default: next_link_sel = FVC_LINK_NONE;
          endcase
        end else begin
          next_quiet = quiet + 13'h0001;
        end
      end
      FVC_ACTIVE: begin
        // Voltage removal ends programming
        if (!vpp_s) begin
          next_state = FVC_IDLE;
          next_link_sel = FVC_LINK_NONE;
        end
      end
      default: next_state = FVC_IDLE;
    endcase
    // The programmer reset overrides every state; it restarts entry
    if (!prst_s) begin
      next_state = FVC_IDLE;
      next_link_sel = FVC_LINK_NONE;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= FVC_IDLE;
      pulses <= 4'h0;
      quiet <= 13'h0000;
      link_sel <= FVC_LINK_NONE;
    end else if (i_ce) begin
      state <= next_state;
      pulses <= next_pulses;
      quiet <= next_quiet;
      link_sel <= next_link_sel;
    end
  end

  // Serial engine: shift in on the selected port, shift out the tx byte in the clocked modes only
  logic [7:0] shreg, next_shreg;
  logic [3:0] bitcnt, next_bitcnt;
  logic [11:0] baud, next_baud;
  logic rx_busy, next_rx_busy;
  logic sout, next_sout;
  logic [7:0] next_rx_byte;
  logic next_rx_valid;
  logic sync_mode, sclk_rise, sclk_fall, sin;
  assign sync_mode = (link_sel == FVC_LINK_A) || (link_sel == FVC_LINK_A_HS) || (link_sel == FVC_LINK_B);
  assign sclk_rise = (link_sel == FVC_LINK_B) ? b_clk_rise : a_clk_rise;
  assign sclk_fall = (link_sel == FVC_LINK_B) ? b_clk_fall : a_clk_fall;
  assign sin = (link_sel == FVC_LINK_B) ? b_in_s : a_in_s;
  always_comb begin
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_baud = baud;
    next_rx_busy = rx_busy;
    next_sout = sout;
    next_rx_byte = o_rx_byte;
    next_rx_valid = 1'b0;
    if (sync_mode) begin
      // Clocked mode: drive on falling edge, sample on rising, MSB first
      if (sclk_fall) begin
        next_sout = (bitcnt == 4'h0) ? i_tx_byte[7] : shreg[7];
        if (bitcnt == 4'h0) begin
          next_shreg = i_tx_byte;
        end
      end
      if (sclk_rise) begin
        next_shreg = {shreg[6:0], sin};
        if (bitcnt == 4'h7) begin
          next_bitcnt = 4'h0;
          next_rx_byte = {shreg[6:0], sin};
          next_rx_valid = 1'b1;
        end else begin
          next_bitcnt = bitcnt + 4'h1;
        end
      end
    end else if (link_sel == FVC_LINK_ASYNC) begin
      // Async receive only; no clock line, 8N1 LSB first
      next_sout = 1'b1;
      if (!rx_busy) begin
        if (!rx_s) begin
          next_rx_busy = 1'b1;
          next_baud = 12'(BAUD_DIV + BAUD_DIV / 2);
          next_bitcnt = 4'h0;
        end
      end else if (baud == 12'h000) begin
        if (bitcnt == 4'h8) begin
          next_rx_busy = 1'b0;
          next_rx_byte = shreg;
          next_rx_valid = rx_s;
        end else begin
          next_shreg = {rx_s, shreg[7:1]};
          next_bitcnt = bitcnt + 4'h1;
          next_baud = 12'(BAUD_DIV - 1);
        end
      end else begin
        next_baud = baud - 12'h001;
      end
    end else begin
      next_bitcnt = 4'h0;
      next_rx_busy = 1'b0;
      next_sout = 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      baud <= 12'h000;
      rx_busy <= 1'b0;
      sout <= 1'b0;
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
    end else if (i_ce) begin
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      baud <= next_baud;
      rx_busy <= next_rx_busy;
      sout <= next_sout;
      o_rx_byte <= next_rx_byte;
      o_rx_valid <= next_rx_valid;
    end
  end

  // Pin outputs: only the chosen port drives, others hold reset level
  logic a_out, b_out, tx_out, hs_out;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_out <= 1'b0;
      b_out <= 1'b0;
      tx_out <= 1'b0;
      hs_out <= 1'b0;
      o_prog_mode <= 1'b0;
      o_link <= FVC_LINK_NONE;
    end else if (i_ce) begin
      a_out <= (link_sel == FVC_LINK_A || link_sel == FVC_LINK_A_HS) ? sout : 1'b0;
      b_out <= (link_sel == FVC_LINK_B) ? sout : 1'b0;
      tx_out <= (link_sel == FVC_LINK_ASYNC) ? sout : 1'b0;
      hs_out <= (link_sel == FVC_LINK_A_HS) && (bitcnt == 4'h0);
      o_prog_mode <= state == FVC_ACTIVE;
      o_link <= link_sel;
    end
  end
  assign link.port_a_serial_out = a_out;
  assign link.port_b_serial_out = b_out;
  assign link.async_transmit = tx_out;
  assign link.handshake_line = hs_out;
endmodule // fvc_device

/* src/fvc_pkg.sv */
// Shared constants for the flash-version memory config and programming-entry ends.
// Assumes both ends share one 200 MHz clock domain and a slow external link.
package fvc_pkg;
  // Memory size select register
  localparam logic [15:0] MSS_ADDR = 16'hfff0; // Register address
  localparam logic [7:0] MSS_RESET = 8'hcf; // Value after reset
  localparam logic [7:0] MSS_SMALL = 8'h46; // Smaller map setting
  localparam logic [7:0] MSS_LARGE = 8'h48; // Larger map setting
  localparam logic [3:0] ROM_CODE_24K = 4'h6; // 24 KB code
  localparam logic [3:0] ROM_CODE_32K = 4'h8; // 32 KB code
  localparam logic [2:0] HRAM_CODE_512 = 3'h2; // 512 byte code
  localparam logic [2:0] HRAM_CODE_1K = 3'h6; // 1,024 byte code
  localparam int ROM_LSB = 0; // Field position
  localparam int HRAM_LSB = 5; // Field position
  // Expansion RAM size select register
  localparam logic [15:0] XRS_ADDR = 16'hfff4; // Register address
  localparam logic [7:0] XRS_RESET = 8'h0c; // Value after reset
  localparam logic [7:0] XRS_INIT = 8'h0b; // Software setup value
  localparam logic [3:0] XRAM_CODE_512 = 4'hb; // 512 byte code
  // Pulse counts per link
  localparam logic [3:0] PULSES_PORT_A = 4'h0; // First three-wire port
  localparam logic [3:0] PULSES_PORT_B = 4'h1; // Second three-wire port
  localparam logic [3:0] PULSES_PORT_A_HS = 4'h3; // First port with handshake
  localparam logic [3:0] PULSES_ASYNC = 4'h8; // Asynchronous port
  // Timing
  localparam int CLK_NS = 5; // Clock period
  localparam int PULSE_WINDOW_NS = 20000; // Quiet time ending the pulse count
  localparam int PULSE_WINDOW_CYC = PULSE_WINDOW_NS / CLK_NS; // 4000 cycles
  localparam int PULSE_HALF_NS = 500; // Programmer pulse half period
  localparam int PULSE_HALF_CYC = PULSE_HALF_NS / CLK_NS; // 100 cycles
  localparam int SCK_DIV = 16; // Link clock half period, cycles
  localparam int BAUD_DIV = 2604; // Async bit time, cycles (76,800 bps)
  // Link choice
  typedef enum logic [2:0] {FVC_LINK_NONE, FVC_LINK_A, FVC_LINK_A_HS, FVC_LINK_B, FVC_LINK_ASYNC} fvc_link_t;
endpackage

/* src/fvc_link_if.sv */
// Link between the device and its flash programmer.
// Assumes the bench resolves nothing: every pin here is single-driver.
`timescale 1ns/100ps
interface fvc_link_if;
  logic vpp; // Programming voltage present, pulsed to choose link
  logic reset_n; // Device reset from programmer, active low
  logic port_a_serial_in; // Programmer to device, port a
  logic port_a_serial_out; // Device to programmer, port a
  logic port_a_serial_clock; // Port a clock from programmer
  logic port_b_serial_in; // Programmer to device, port b
  logic port_b_serial_out; // Device to programmer, port b
  logic port_b_serial_clock; // Port b clock from programmer
  logic async_receive; // Programmer to device, async
  logic async_transmit; // Device to programmer, async
  logic handshake_line; // Device ready, to programmer
  logic main_clock_input; // Clock the programmer may supply
  modport device (input vpp, reset_n, port_a_serial_in, port_a_serial_clock, port_b_serial_in,
    port_b_serial_clock, async_receive, main_clock_input,
    output port_a_serial_out, port_b_serial_out, async_transmit, handshake_line);
  modport programmer (output vpp, reset_n, port_a_serial_in, port_a_serial_clock, port_b_serial_in,
    port_b_serial_clock, async_receive, main_clock_input,
    input port_a_serial_out, port_b_serial_out, async_transmit, handshake_line);
endinterface

/* src/fvc_programmer.sv */
// Programmer end: drives reset, voltage pulses and the chosen serial link.
// Assumes the bench joins it to the device end through fvc_link_if.
`timescale 1ns/100ps
module fvc_programmer (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire fvc_pkg::fvc_link_t i_link,
  input wire logic i_send,
  input wire logic [7:0] i_tx_byte,
  output logic o_ready,
  output logic o_busy,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  fvc_link_if.programmer link
);
  import fvc_pkg::*;

  typedef enum {FVP_IDLE, FVP_RESET, FVP_PULSE, FVP_WAIT, FVP_READY, FVP_XFER} fvp_state_t;

  // Synchronise device outputs
  logic [3:0] in_meta, in_sync;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
    end else if (i_ce) begin
      in_meta <= {link.port_a_serial_out, link.port_b_serial_out, link.async_transmit, link.handshake_line};
      in_sync <= in_meta;
    end
  end

  fvp_state_t state, next_state;
  fvc_link_t mode, next_mode;
  logic [3:0] pulses_left, next_pulses_left;
  logic [12:0] cnt, next_cnt;
  logic [3:0] bits, next_bits;
  logic [7:0] txsh, next_txsh, rxsh, next_rxsh;
  logic vpp, next_vpp, rst_n, next_rst_n, sck, next_sck, sdo, next_sdo;
  logic [7:0] next_rx_byte;
  logic next_rx_valid;
  logic dev_bit; // Device data bit of the chosen clocked port
  assign dev_bit = (mode == FVC_LINK_B) ? in_sync[2] : in_sync[3];
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_pulses_left = pulses_left;
    next_cnt = cnt;
    next_bits = bits;
    next_txsh = txsh;
    next_rxsh = rxsh;
    next_vpp = vpp;
    next_rst_n = rst_n;
    next_sck = sck;
    next_sdo = sdo;
    next_rx_byte = o_rx_byte;
    next_rx_valid = 1'b0;
    case (state)
      FVP_IDLE, FVP_READY: begin
        // A new entry may begin when idle or between bytes
        if (i_start) begin
          next_state = FVP_RESET;
          next_sdo = 1'b1; // Async receive line idles high from the start
          next_mode = i_link;
          next_rst_n = 1'b0;
          next_vpp = 1'b1;
          next_cnt = 13'h0000;
          case (i_link)
            FVC_LINK_A_HS: next_pulses_left = PULSES_PORT_A_HS;
            FVC_LINK_B: next_pulses_left = PULSES_PORT_B;
            FVC_LINK_ASYNC: next_pulses_left = PULSES_ASYNC;
            default: next_pulses_left = PULSES_PORT_A;
          endcase
        end else if (state == FVP_READY && i_send && (mode != FVC_LINK_A_HS || in_sync[0])) begin
          next_state = FVP_XFER;
          next_txsh = i_tx_byte;
          next_bits = 4'h0;
          next_cnt = 13'h0000;
          if (mode == FVC_LINK_ASYNC) begin
            next_sdo = 1'b0; // Start bit
          end else begin
            next_sdo = i_tx_byte[7];
          end
        end
      end
      FVP_RESET: begin
        // Hold reset, then release with voltage present
        next_cnt = cnt + 13'h0001;
        if (cnt == 13'(PULSE_HALF_CYC)) begin
          next_rst_n = 1'b1;
          next_cnt = 13'h0000;
          next_state = FVP_PULSE;
        end
      end
      FVP_PULSE: begin
        // Each pulse: high half then low half
        next_cnt = cnt + 13'h0001;
        if (pulses_left == 4'h0) begin
          next_state = FVP_WAIT;
          next_cnt = 13'h0000;
        end else if (cnt == 13'(PULSE_HALF_CYC - 1)) begin
          next_vpp = 1'b0;
        end else if (cnt == 13'(2 * PULSE_HALF_CYC - 1)) begin
          next_vpp = 1'b1;
          next_cnt = 13'h0000;
          next_pulses_left = pulses_left - 4'h1;
        end
      end
      FVP_WAIT: begin
        // Outlast the device quiet window
        next_cnt = cnt + 13'h0001;
        if (cnt == 13'(PULSE_WINDOW_CYC + 4 * PULSE_HALF_CYC)) begin
          next_state = FVP_READY;
          next_sdo = mode != FVC_LINK_ASYNC ? 1'b0 : 1'b1;
        end
      end
      FVP_XFER: begin
        next_cnt = cnt + 13'h0001;
        if (mode == FVC_LINK_ASYNC) begin
          // Async send, LSB first, no clock line
          if (cnt == 13'(BAUD_DIV - 1)) begin
            next_cnt = 13'h0000;
            next_bits = bits + 4'h1;
            if (bits == 4'h9) begin
              next_state = FVP_READY;
            end else if (bits == 4'h8) begin
              next_sdo = 1'b1;
            end else begin
              next_sdo = txsh[bits[2:0]];
            end
          end
        end else if (cnt == 13'(SCK_DIV - 1)) begin
          // Clocked send: data set while clock low, sampled on rise
          next_cnt = 13'h0000;
          next_sck = ~sck;
          if (sck) begin
            // Falling edge: present the current bit
            next_sdo = txsh[7];
          end else begin
            // Rising edge: both ends sample, the eighth rise ends the byte with the clock high
            next_rxsh = {rxsh[6:0], dev_bit};
            next_txsh = {txsh[6:0], 1'b0};
            next_bits = bits + 4'h1;
            if (bits == 4'h7) begin
              next_state = FVP_READY;
              next_rx_byte = {rxsh[6:0], dev_bit};
              next_rx_valid = 1'b1;
            end
          end
        end
      end
      default: next_state = FVP_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= FVP_IDLE;
      mode <= FVC_LINK_NONE;
      pulses_left <= 4'h0;
      cnt <= 13'h0000;
      bits <= 4'h0;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      vpp <= 1'b0;
      rst_n <= 1'b0;
      sck <= 1'b1;
      sdo <= 1'b1;
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
      o_ready <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      mode <= next_mode;
      pulses_left <= next_pulses_left;
      cnt <= next_cnt;
      bits <= next_bits;
      txsh <= next_txsh;
      rxsh <= next_rxsh;
      vpp <= next_vpp;
      rst_n <= next_rst_n;
      sck <= next_sck;
      sdo <= next_sdo;
      o_rx_byte <= next_rx_byte;
      o_rx_valid <= next_rx_valid;
      o_ready <= next_state == FVP_READY;
      o_busy <= next_state != FVP_IDLE && next_state != FVP_READY;
    end
  end
  assign link.vpp = vpp;
  assign link.reset_n = rst_n;
  assign link.port_a_serial_in = sdo;
  assign link.port_b_serial_in = sdo;
  assign link.async_receive = sdo;
  assign link.port_a_serial_clock = (mode == FVC_LINK_A || mode == FVC_LINK_A_HS) ? sck : 1'b1;
  assign link.port_b_serial_clock = (mode == FVC_LINK_B) ? sck : 1'b1;
  assign link.main_clock_input = 1'b0;
endmodule // fvc_programmer

/* testbench/fvc_link_assertions.sv */
// Checker for the programming link that joins the device end to the programmer end.
// Assumes the bench instantiates it beside the shared link interface, on the device clock.
`timescale 1ns/100ps
module fvc_link_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic vpp,
  input wire logic reset_n,
  input wire logic port_a_serial_clock,
  input wire logic port_b_serial_clock,
  input wire logic async_receive,
  input wire logic port_a_serial_out,
  input wire logic port_b_serial_out,
  input wire logic async_transmit,
  input wire logic handshake_line
);
  // One domain, so one default clock and disable
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Never two serial clocks moving together
  one_link_clock_a: assert property ($changed(port_a_serial_clock) |-> $stable(port_b_serial_clock))
    else $error("both serial clocks moved");
  // Second port alone on the wire
  port_b_alone_a: assert property (port_b_serial_out |-> !port_a_serial_out && !handshake_line)
    else $error("second port shares the wire");
  // Async transmit implies no clocked output
  async_alone_a: assert property (async_transmit |-> !port_a_serial_out && !port_b_serial_out)
    else $error("async shares the wire");
  // Handshake only with the first port
  handshake_alone_a: assert property (handshake_line |-> !async_transmit && !port_b_serial_out)
    else $error("handshake outside its mode");
  // Held reset leaves every device output at its reset level
  reset_quiet_a: assert property (!reset_n [*6] |->
    !(port_a_serial_out || port_b_serial_out || async_transmit || handshake_line))
    else $error("device output active in reset");
  // Second-port device data moves only while its clock is low
  out_on_fall_a: assert property (vpp && reset_n && $changed(port_b_serial_out) |-> !port_b_serial_clock)
    else $error("data moved while clock high");
  // Clocks stand still outside programming
  clock_idle_a: assert property (!vpp |-> port_a_serial_clock && port_b_serial_clock)
    else $error("serial clock moved without voltage");
  // Async traffic runs with no serial clock
  async_no_clock_a: assert property (async_transmit && $changed(async_receive) |=>
    port_a_serial_clock && port_b_serial_clock)
    else $error("serial clock in async mode");
endmodule // fvc_link_assertions

/* testbench/tb_top.sv */
// Top bench: both ends joined by the link, registers and each link mode exercised.
// Assumes the package constants and a 200 MHz clock.
`timescale 1ns/100ps
module tb_top;
  import fvc_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic start = 1'h0;
  logic send = 1'h0;
  logic [15:0] addr = 16'h0;
  logic [7:0] wdata = 8'h0;
  fvc_link_t link_sel = FVC_LINK_NONE;
  fvc_link_t link_out;
  logic [7:0] rdata, d_rx, p_rx, d_got, p_got;
  logic [3:0] rom_f;
  logic [2:0] hram_f;
  logic rvalid, d_rxv, p_rxv, ready, busy, prog, rom_ok, xram_ok;
  logic d_seen = 1'h0;
  logic p_seen = 1'h0;
  int n_fail = 0;
  int n_compared = 0;
  // Rows: address, write data, read back, flag
  logic [39:0] rows [6] = '{{MSS_ADDR, MSS_SMALL, MSS_SMALL, 8'h1}, {MSS_ADDR, MSS_LARGE, MSS_LARGE, 8'h1},
    {MSS_ADDR, 8'h5f, 8'h4f, 8'h0}, {MSS_ADDR, 8'hc8, 8'hc8, 8'h1}, {XRS_ADDR, XRS_INIT, XRS_INIT, 8'h1},
    {XRS_ADDR, 8'hfc, 8'h0c, 8'h0}};
  fvc_link_t modes [4] = '{FVC_LINK_A, FVC_LINK_A_HS, FVC_LINK_B, FVC_LINK_ASYNC};
  fvc_link_if lk ();
  always #2.5 clk = ~clk;
  fvc_device i_fvc_device (.i_clk(clk), .i_reset_n(rst_n), .i_ce(1'h1), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_tx_byte(8'ha5), .o_rdata(rdata), .o_rvalid(rvalid), .o_rom_size_field(rom_f),
    .o_hram_size_field(hram_f), .o_rom_setting_valid(rom_ok), .o_xram_512(xram_ok), .o_prog_mode(prog),
    .o_link(link_out), .o_rx_byte(d_rx), .o_rx_valid(d_rxv), .link(lk.device));
  fvc_programmer i_fvc_programmer (.i_clk(clk), .i_reset_n(rst_n), .i_ce(1'h1), .i_start(start),
    .i_link(link_sel), .i_send(send), .i_tx_byte(8'h3c), .o_ready(ready), .o_busy(busy), .o_rx_byte(p_rx),
    .o_rx_valid(p_rxv), .link(lk.programmer));
  fvc_link_assertions i_fvc_link_assertions (.i_clk(clk), .i_reset_n(rst_n), .vpp(lk.vpp), .reset_n(lk.reset_n),
    .port_a_serial_clock(lk.port_a_serial_clock), .port_b_serial_clock(lk.port_b_serial_clock),
    .async_receive(lk.async_receive), .port_a_serial_out(lk.port_a_serial_out),
    .port_b_serial_out(lk.port_b_serial_out), .async_transmit(lk.async_transmit),
    .handshake_line(lk.handshake_line));
  // Latch one-cycle receive pulses so waits cannot miss them
  always @(posedge clk) begin
    if (d_rxv === 1'h1) begin
      d_got <= d_rx;
      d_seen <= 1'h1;
    end
    if (p_rxv === 1'h1) begin
      p_got <= p_rx;
      p_seen <= 1'h1;
    end
  end
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a level; running out ends the run
  task automatic wait_lvl(ref logic f, input logic lvl, input int lim);
    int k;
    k = 0;
    while (f !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
    if (f !== lvl) begin
      n_fail++;
      $display("mismatch wait expected %b seen %b", lvl, f);
      stop_test();
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    wait_lvl(rvalid, 1'h1, 4);
    chk(what, exp, rdata);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    rd_reg(MSS_ADDR, MSS_RESET, "mss reset");
    rd_reg(XRS_ADDR, XRS_RESET, "xrs reset");
    rd_reg(16'hff00, 8'h00, "unmapped");
    foreach (rows[i]) begin
      wr_reg(rows[i][39:24], rows[i][23:16]);
      rd_reg(rows[i][39:24], rows[i][15:8], "reg value");
      if (rows[i][39:24] == MSS_ADDR) begin
        chk("rom field", {4'h0, rows[i][11:8]}, {4'h0, rom_f});
        chk("hram field", {5'h0, rows[i][15:13]}, {5'h0, hram_f});
        chk("rom valid", rows[i][7:0], {7'h0, rom_ok});
      end else
        chk("xram valid", rows[i][7:0], {7'h0, xram_ok});
    end
    wr_reg(XRS_ADDR, XRS_INIT);
    rd_reg(XRS_ADDR, XRS_INIT, "xrs init");
    foreach (modes[i]) begin
      @(negedge clk);
      link_sel = modes[i];
      start = 1'h1;
      d_seen = 1'h0;
      p_seen = 1'h0;
      @(negedge clk);
      start = 1'h0;
      chk("busy", 8'h01, {7'h0, busy});
      wait_lvl(prog, 1'h0, 400);
      wait_lvl(prog, 1'h1, 12000);
      chk("link", {5'h0, modes[i]}, {5'h0, link_out});
      wait_lvl(ready, 1'h1, 2000);
      chk("ready busy", 8'h00, {7'h0, busy});
      send = 1'h1;
      @(negedge clk);
      send = 1'h0;
      wait_lvl(d_seen, 1'h1, 30000);
      chk("device rx", 8'h3c, d_got);
      if (modes[i] != FVC_LINK_ASYNC) begin
        wait_lvl(p_seen, 1'h1, 2000);
        chk("programmer rx", 8'ha5, p_got);
      end
    end
    stop_test();
  end
endmodule // tb_top
